// ### core/pwmcmd_pkg.sv
package pwmcmd_pkg;
  localparam logic [7:0] CMD_OUT_FORMAT = 8'h20;
  localparam logic [7:0] CMD_OUT_TARGET = 8'h21;
  localparam logic [7:0] CMD_OUT_CEILING = 8'h24;
  localparam logic [7:0] CMD_MARGIN_HIGH = 8'h25;
  localparam logic [7:0] CMD_MARGIN_LOW = 8'h26;
  localparam logic [7:0] CMD_IN_ON = 8'h35;
  localparam logic [7:0] CMD_IN_OFF = 8'h36;
  localparam logic [7:0] CMD_OUT_OV_FAULT = 8'h40;
  localparam logic [7:0] CMD_OUT_OV_WARN = 8'h42;
  localparam logic [7:0] CMD_OUT_UV_WARN = 8'h43;
  localparam logic [7:0] CMD_OUT_UV_FAULT = 8'h44;
  localparam logic [7:0] CMD_IN_OV_FAULT = 8'h55;
  localparam logic [7:0] CMD_IN_UV_WARN = 8'h58;
  localparam logic [7:0] CMD_OUT_HARD_MAX = 8'ha5;
  localparam logic [7:0] CMD_LOAD_LINE = 8'hd3;
  localparam logic [7:0] CMD_PWM_MODE = 8'hd4;
  localparam logic [7:0] RST_OUT_FORMAT = 8'h14;
  localparam logic [15:0] RST_OUT_TARGET = 16'h1000;
  localparam logic [15:0] RST_OUT_CEILING = 16'h5800;
  localparam logic [15:0] RST_MARGIN_HIGH = 16'h10cd;
  localparam logic [15:0] RST_MARGIN_LOW = 16'h0f33;
  localparam logic [15:0] RST_IN_ON = 16'hcb40;
  localparam logic [15:0] RST_IN_OFF = 16'hcb00;
  localparam logic [15:0] RST_OUT_OV_FAULT = 16'h119a;
  localparam logic [15:0] RST_OUT_OV_WARN = 16'h1133;
  localparam logic [15:0] RST_OUT_UV_WARN = 16'h0ecd;
  localparam logic [15:0] RST_OUT_UV_FAULT = 16'h0e66;
  localparam logic [15:0] RST_IN_OV_FAULT = 16'hd3e0;
  localparam logic [15:0] RST_IN_UV_WARN = 16'hcb26;
  localparam logic [15:0] RST_OUT_HARD_MAX = 16'h599a;
  localparam logic [15:0] RST_LOAD_LINE = 16'h8000;
  localparam logic [7:0] RST_PWM_MODE = 8'h00;
  localparam int BIT_RANGE = 7;
  localparam int BIT_SERVO = 6;
  localparam int BIT_TEMP_DIRECT = 5;
  localparam int BIT_REFRESH_HI = 4;
  localparam int BIT_REFRESH_LO = 3;
  localparam int BIT_PROTOCOL = 1;
  localparam int BIT_DISCONT = 0;
  localparam int REFRESH_NS_0 = 25;
  localparam int REFRESH_NS_1 = 50;
  localparam int REFRESH_NS_2 = 125;
  localparam int REFRESH_NS_3 = 250;
  localparam int CLK_PERIOD_NS = 5;
  localparam logic [7:0] REFRESH_CYC_0 = 8'((REFRESH_NS_0 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [7:0] REFRESH_CYC_1 = 8'((REFRESH_NS_1 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [7:0] REFRESH_CYC_2 = 8'((REFRESH_NS_2 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [7:0] REFRESH_CYC_3 = 8'((REFRESH_NS_3 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [15:0] RAMP_STEP = 16'h0001;
endpackage

// ### core/pwmcmd_regs.sv
`timescale 1ns/1ps
// Overview of operation
// - Mode write while running: refuse, busy fault
// - Bit 7 picks output range limit
// - Bit 6 servo, forced off by load-line
// - Bit 5 picks temperature sense method
// - Direct-mode temperature formula, done downstream
// - Difference-mode temperature formula, done downstream
// - Bits 4:3 set refresh pulse width
// - Bit 1 selects PWM protocol variant
// - Bit 0 selects continuous or discontinuous
// - Start conversion only after input on-threshold
// - Stop conversion at input off-threshold
// - Input overvoltage fault above limit
// - Input UV warning inhibited until started
// - UV warning sets status bits and alert
// - Format byte reads fixed 0x14
// - Write to format byte: communication fault
// - Target change waits for ramps, then slews
// - Hard maximum readable, read-only
module pwmcmd_regs (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Command port
  input wire logic cmd_valid,
  input wire logic cmd_write,
  input wire logic [7:0] cmd_code,
  input wire logic [15:0] cmd_wdata,
  output logic cmd_nack,
  output logic [15:0] cmd_rdata,
  // Channel state and measurement
  input wire logic chan_running,
  input wire logic chan_enable,
  input wire logic seq_ramping,
  input wire logic [15:0] vin_meas,
  input wire logic alert_mask_vin_uv,
  // Status and controls
  output logic fault_busy,
  output logic fault_cml,
  output logic conversion_on,
  output logic vin_ov_fault,
  output logic status_word_input,
  output logic status_input_uv_warn,
  output logic alert_n,
  output logic range_low,
  output logic servo_enable,
  output logic temp_direct,
  output logic [7:0] refresh_cycles,
  output logic pwm_protocol_alt,
  output logic discontinuous_conduction,
  output logic [15:0] vout_setpoint
);
  typedef struct packed {
    logic [15:0] out_target;
    logic [15:0] out_ceiling;
    logic [15:0] margin_high;
    logic [15:0] margin_low;
    logic [15:0] in_on;
    logic [15:0] in_off;
    logic [15:0] out_ov_fault;
    logic [15:0] out_ov_warn;
    logic [15:0] out_uv_warn;
    logic [15:0] out_uv_fault;
    logic [15:0] in_ov_fault;
    logic [15:0] in_uv_warn;
    logic [15:0] load_line;
    logic [7:0] pwm_mode;
    logic [15:0] setpoint;
    logic [15:0] rdata;
    logic nack;
    logic busy;
    logic cml;
    logic conv;
    logic ovf;
    logic uv_armed;
    logic uv_warn;
  } pwmcmd_state_t;

  pwmcmd_state_t st, nx;

  // Load-line of +0.0 (zero mantissa) leaves servo allowed
  function automatic logic pwmcmd_nonzero_l11(input logic [15:0] v);
    return v[10:0] != 11'h000;
  endfunction

  // Linear-11 compare: exponent offset by 16 into a shift, mantissa sign-extended
  function automatic logic signed [47:0] pwmcmd_l11(input logic [15:0] v);
    logic signed [4:0] e;
    logic signed [47:0] m;
    e = v[15:11];
    m = 48'(signed'(v[10:0]));
    return m <<< (5'(e) + 5'h10);
  endfunction

  // Input voltage against thresholds, shared by the control and its checks
  logic vin_ge_on;
  logic vin_gt_on;
  logic vin_le_off;
  logic vin_gt_ov;
  logic vin_lt_uv;
  assign vin_ge_on = pwmcmd_l11(vin_meas) >= pwmcmd_l11(st.in_on);
  assign vin_gt_on = pwmcmd_l11(vin_meas) > pwmcmd_l11(st.in_on);
  assign vin_le_off = pwmcmd_l11(vin_meas) <= pwmcmd_l11(st.in_off);
  assign vin_gt_ov = pwmcmd_l11(vin_meas) > pwmcmd_l11(st.in_ov_fault);
  assign vin_lt_uv = pwmcmd_l11(vin_meas) < pwmcmd_l11(st.in_uv_warn);

  always_comb begin
    nx = st;
    nx.nack = 1'b0;
    if (cmd_valid && cmd_write) begin
      case (cmd_code)
        pwmcmd_pkg::CMD_PWM_MODE: begin
          if (chan_running) begin
            nx.nack = 1'b1;
            nx.busy = 1'b1;
          end else begin
            nx.pwm_mode = cmd_wdata[7:0];
          end
        end
        pwmcmd_pkg::CMD_OUT_FORMAT: begin
          nx.cml = 1'b1;
        end
        pwmcmd_pkg::CMD_OUT_HARD_MAX: begin
          nx.cml = 1'b1;
        end
        pwmcmd_pkg::CMD_OUT_TARGET: nx.out_target = cmd_wdata;
        pwmcmd_pkg::CMD_OUT_CEILING: nx.out_ceiling = cmd_wdata;
        pwmcmd_pkg::CMD_MARGIN_HIGH: nx.margin_high = cmd_wdata;
        pwmcmd_pkg::CMD_MARGIN_LOW: nx.margin_low = cmd_wdata;
        pwmcmd_pkg::CMD_IN_ON: nx.in_on = cmd_wdata;
        pwmcmd_pkg::CMD_IN_OFF: nx.in_off = cmd_wdata;
        pwmcmd_pkg::CMD_OUT_OV_FAULT: nx.out_ov_fault = cmd_wdata;
        pwmcmd_pkg::CMD_OUT_OV_WARN: nx.out_ov_warn = cmd_wdata;
        pwmcmd_pkg::CMD_OUT_UV_WARN: nx.out_uv_warn = cmd_wdata;
        pwmcmd_pkg::CMD_OUT_UV_FAULT: nx.out_uv_fault = cmd_wdata;
        pwmcmd_pkg::CMD_IN_OV_FAULT: nx.in_ov_fault = cmd_wdata;
        pwmcmd_pkg::CMD_IN_UV_WARN: nx.in_uv_warn = cmd_wdata;
        pwmcmd_pkg::CMD_LOAD_LINE: nx.load_line = cmd_wdata;
        default: nx.nack = 1'b1;
      endcase
    end
    if (cmd_valid && !cmd_write) begin
      case (cmd_code)
        pwmcmd_pkg::CMD_OUT_FORMAT: nx.rdata = {8'h00, pwmcmd_pkg::RST_OUT_FORMAT};
        pwmcmd_pkg::CMD_OUT_HARD_MAX: nx.rdata = pwmcmd_pkg::RST_OUT_HARD_MAX;
        pwmcmd_pkg::CMD_OUT_TARGET: nx.rdata = st.out_target;
        pwmcmd_pkg::CMD_OUT_CEILING: nx.rdata = st.out_ceiling;
        pwmcmd_pkg::CMD_MARGIN_HIGH: nx.rdata = st.margin_high;
        pwmcmd_pkg::CMD_MARGIN_LOW: nx.rdata = st.margin_low;
        pwmcmd_pkg::CMD_IN_ON: nx.rdata = st.in_on;
        pwmcmd_pkg::CMD_IN_OFF: nx.rdata = st.in_off;
        pwmcmd_pkg::CMD_OUT_OV_FAULT: nx.rdata = st.out_ov_fault;
        pwmcmd_pkg::CMD_OUT_OV_WARN: nx.rdata = st.out_ov_warn;
        pwmcmd_pkg::CMD_OUT_UV_WARN: nx.rdata = st.out_uv_warn;
        pwmcmd_pkg::CMD_OUT_UV_FAULT: nx.rdata = st.out_uv_fault;
        pwmcmd_pkg::CMD_IN_OV_FAULT: nx.rdata = st.in_ov_fault;
        pwmcmd_pkg::CMD_IN_UV_WARN: nx.rdata = st.in_uv_warn;
        pwmcmd_pkg::CMD_LOAD_LINE: nx.rdata = st.load_line;
        pwmcmd_pkg::CMD_PWM_MODE: nx.rdata = {8'h00, st.pwm_mode};
        default: begin
          nx.rdata = 16'h0000;
          nx.nack = 1'b1;
        end
      endcase
    end
    // Conversion hysteresis between on and off thresholds
    if (!st.conv && vin_ge_on) begin
      nx.conv = 1'b1;
    end else if (st.conv && vin_le_off) begin
      nx.conv = 1'b0;
    end
    if (vin_gt_ov) begin
      nx.ovf = 1'b1;
    end
    if (vin_gt_on && chan_enable) begin
      nx.uv_armed = 1'b1;
    end
    if (st.uv_armed && vin_lt_uv) begin
      nx.uv_warn = 1'b1;
    end
    // Setpoint holds during ramps, otherwise slews one step per cycle
    if (!seq_ramping) begin
      if (st.setpoint < st.out_target) begin
        nx.setpoint = st.setpoint + pwmcmd_pkg::RAMP_STEP;
      end else if (st.setpoint > st.out_target) begin
        nx.setpoint = st.setpoint - pwmcmd_pkg::RAMP_STEP;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
      st.out_target <= pwmcmd_pkg::RST_OUT_TARGET;
      st.out_ceiling <= pwmcmd_pkg::RST_OUT_CEILING;
      st.margin_high <= pwmcmd_pkg::RST_MARGIN_HIGH;
      st.margin_low <= pwmcmd_pkg::RST_MARGIN_LOW;
      st.in_on <= pwmcmd_pkg::RST_IN_ON;
      st.in_off <= pwmcmd_pkg::RST_IN_OFF;
      st.out_ov_fault <= pwmcmd_pkg::RST_OUT_OV_FAULT;
      st.out_ov_warn <= pwmcmd_pkg::RST_OUT_OV_WARN;
      st.out_uv_warn <= pwmcmd_pkg::RST_OUT_UV_WARN;
      st.out_uv_fault <= pwmcmd_pkg::RST_OUT_UV_FAULT;
      st.in_ov_fault <= pwmcmd_pkg::RST_IN_OV_FAULT;
      st.in_uv_warn <= pwmcmd_pkg::RST_IN_UV_WARN;
      st.load_line <= pwmcmd_pkg::RST_LOAD_LINE;
      st.pwm_mode <= pwmcmd_pkg::RST_PWM_MODE;
      st.setpoint <= pwmcmd_pkg::RST_OUT_TARGET;
    end else begin
      st <= nx;
    end
  end

  assign cmd_nack = st.nack;
  assign cmd_rdata = st.rdata;
  assign fault_busy = st.busy;
  assign fault_cml = st.cml;
  assign conversion_on = st.conv;
  assign vin_ov_fault = st.ovf;
  assign status_word_input = st.uv_warn;
  assign status_input_uv_warn = st.uv_warn;
  assign alert_n = !(st.uv_warn && !alert_mask_vin_uv);
  assign range_low = st.pwm_mode[pwmcmd_pkg::BIT_RANGE];
  assign servo_enable = st.pwm_mode[pwmcmd_pkg::BIT_SERVO] &&
                        !pwmcmd_nonzero_l11(st.load_line);
  assign temp_direct = st.pwm_mode[pwmcmd_pkg::BIT_TEMP_DIRECT];
  assign pwm_protocol_alt = st.pwm_mode[pwmcmd_pkg::BIT_PROTOCOL];
  assign discontinuous_conduction = st.pwm_mode[pwmcmd_pkg::BIT_DISCONT];
  assign vout_setpoint = st.setpoint;

  always_comb begin
    case (st.pwm_mode[pwmcmd_pkg::BIT_REFRESH_HI:pwmcmd_pkg::BIT_REFRESH_LO])
      2'b11: refresh_cycles = pwmcmd_pkg::REFRESH_CYC_3;
      2'b10: refresh_cycles = pwmcmd_pkg::REFRESH_CYC_2;
      2'b01: refresh_cycles = pwmcmd_pkg::REFRESH_CYC_1;
      default: refresh_cycles = pwmcmd_pkg::REFRESH_CYC_0;
    endcase
  end

  // Command refusals and the mode byte
  AST_BUSY_NACK: assert property (@(posedge clk) disable iff (!rst_n)
    cmd_valid && cmd_write && cmd_code == pwmcmd_pkg::CMD_PWM_MODE && chan_running
    |=> cmd_nack && fault_busy && $stable(st.pwm_mode))
    else $error("busy refusal");
  AST_MODE_IDLE: assert property (@(posedge clk) disable iff (!rst_n)
    cmd_valid && cmd_write && cmd_code == pwmcmd_pkg::CMD_PWM_MODE && !chan_running
    |=> !cmd_nack && fault_busy == $past(fault_busy))
    else $error("idle mode write refused");
  AST_MODE_STORE: assert property (@(posedge clk) disable iff (!rst_n)
    cmd_valid && cmd_write && cmd_code == pwmcmd_pkg::CMD_PWM_MODE && !chan_running
    |=> {8'h00, st.pwm_mode} == ($past(cmd_wdata) & 16'h00ff))
    else $error("mode byte not stored");
  AST_MODE_DECODE: assert property (@(posedge clk) disable iff (!rst_n)
    cmd_valid && cmd_write && cmd_code == pwmcmd_pkg::CMD_PWM_MODE && !chan_running
    |=> {8'h00, range_low, 1'h0, temp_direct, 3'h0, pwm_protocol_alt, discontinuous_conduction}
        == ($past(cmd_wdata) & 16'h00a3))
    else $error("mode bits not decoded");
  AST_FORMAT_WRITE: assert property (@(posedge clk) disable iff (!rst_n)
    cmd_valid && cmd_write && cmd_code == pwmcmd_pkg::CMD_OUT_FORMAT
    |=> fault_cml && !cmd_nack)
    else $error("format write no cml");
  AST_FORMAT_READ: assert property (@(posedge clk) disable iff (!rst_n)
    cmd_valid && !cmd_write && cmd_code == pwmcmd_pkg::CMD_OUT_FORMAT
    |=> cmd_rdata == 16'h0014)
    else $error("format value wrong");
  AST_HARDMAX_WRITE: assert property (@(posedge clk) disable iff (!rst_n)
    cmd_valid && cmd_write && cmd_code == pwmcmd_pkg::CMD_OUT_HARD_MAX
    |=> fault_cml)
    else $error("hard max write no cml");
  AST_HARDMAX: assert property (@(posedge clk) disable iff (!rst_n)
    cmd_valid && !cmd_write && cmd_code == pwmcmd_pkg::CMD_OUT_HARD_MAX
    |=> cmd_rdata == 16'h599a)
    else $error("hard max wrong");
  AST_CML_STICKY: assert property (@(posedge clk) disable iff (!rst_n)
    fault_cml |=> fault_cml)
    else $error("cml fault dropped");

  // Mode decode
  AST_SERVO_GATE: assert property (@(posedge clk) disable iff (!rst_n)
    st.load_line[10:0] != 11'h000 |-> !servo_enable)
    else $error("servo not gated");
  AST_SERVO_PASS: assert property (@(posedge clk) disable iff (!rst_n)
    st.load_line[10:0] == 11'h000 |-> servo_enable == st.pwm_mode[pwmcmd_pkg::BIT_SERVO])
    else $error("servo bit lost");
  AST_REFRESH_3: assert property (@(posedge clk) disable iff (!rst_n)
    st.pwm_mode[pwmcmd_pkg::BIT_REFRESH_HI:pwmcmd_pkg::BIT_REFRESH_LO] == 2'h3
    |-> refresh_cycles == 8'h32)
    else $error("refresh width 250");
  AST_REFRESH_2: assert property (@(posedge clk) disable iff (!rst_n)
    st.pwm_mode[pwmcmd_pkg::BIT_REFRESH_HI:pwmcmd_pkg::BIT_REFRESH_LO] == 2'h2
    |-> refresh_cycles == 8'h19)
    else $error("refresh width 125");
  AST_REFRESH_1: assert property (@(posedge clk) disable iff (!rst_n)
    st.pwm_mode[pwmcmd_pkg::BIT_REFRESH_HI:pwmcmd_pkg::BIT_REFRESH_LO] == 2'h1
    |-> refresh_cycles == 8'h0a)
    else $error("refresh width 50");
  AST_REFRESH_0: assert property (@(posedge clk) disable iff (!rst_n)
    st.pwm_mode[pwmcmd_pkg::BIT_REFRESH_HI:pwmcmd_pkg::BIT_REFRESH_LO] == 2'h0
    |-> refresh_cycles == 8'h05)
    else $error("refresh width 25");

  // Input thresholds and warnings
  AST_CONV_START: assert property (@(posedge clk) disable iff (!rst_n)
    !conversion_on && !vin_ge_on |=> !conversion_on)
    else $error("conversion began below on threshold");
  AST_CONV_RISE: assert property (@(posedge clk) disable iff (!rst_n)
    !conversion_on && vin_ge_on |=> conversion_on)
    else $error("conversion did not start");
  AST_CONV_STOP: assert property (@(posedge clk) disable iff (!rst_n)
    conversion_on && vin_le_off |=> !conversion_on)
    else $error("conversion did not stop");
  AST_OV_SET: assert property (@(posedge clk) disable iff (!rst_n)
    vin_gt_ov |=> vin_ov_fault)
    else $error("input ov not flagged");
  AST_OV_STICKY: assert property (@(posedge clk) disable iff (!rst_n)
    vin_ov_fault |=> vin_ov_fault)
    else $error("input ov dropped");
  AST_UV_INHIBIT: assert property (@(posedge clk) disable iff (!rst_n)
    !st.uv_armed |=> !status_input_uv_warn || $past(status_input_uv_warn))
    else $error("uv warn while inhibited");
  AST_UV_SET: assert property (@(posedge clk) disable iff (!rst_n)
    st.uv_armed && vin_lt_uv |=> status_input_uv_warn && status_word_input)
    else $error("uv warn not raised");
  AST_ALERT: assert property (@(posedge clk) disable iff (!rst_n)
    status_input_uv_warn && !alert_mask_vin_uv |-> !alert_n && status_word_input)
    else $error("alert missing");
  AST_ALERT_MASK: assert property (@(posedge clk) disable iff (!rst_n)
    alert_mask_vin_uv |-> alert_n)
    else $error("masked alert raised");

  // Output setpoint
  AST_RAMP_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
    seq_ramping |=> $stable(vout_setpoint))
    else $error("setpoint moved in ramp");
  AST_RAMP_UP: assert property (@(posedge clk) disable iff (!rst_n)
    !seq_ramping && vout_setpoint < st.out_target
    |=> vout_setpoint == $past(vout_setpoint) + 16'h0001)
    else $error("setpoint did not step up");
  AST_RAMP_DOWN: assert property (@(posedge clk) disable iff (!rst_n)
    !seq_ramping && vout_setpoint > st.out_target
    |=> vout_setpoint == $past(vout_setpoint) - 16'h0001)
    else $error("setpoint did not step down");
endmodule

// ### bench/pwmcmd_host.sv
`timescale 1ns/1ps
module pwmcmd_host (
  // Clock
  input wire logic clk,
  // Command port
  output logic cmd_valid,
  output logic cmd_write,
  output logic [7:0] cmd_code,
  output logic [15:0] cmd_wdata,
  input wire logic cmd_nack,
  input wire logic [15:0] cmd_rdata
);
  initial begin
    cmd_valid = 1'b0;
    cmd_write = 1'b0;
    cmd_code = 8'h00;
    cmd_wdata = 16'h0000;
  end
  // Request is held across one sampling edge; the answer is taken half a cycle after that edge
  task automatic xfer(input logic w, input logic [7:0] c, input logic [15:0] d,
                      output logic nack, output logic [15:0] rd);
    @(negedge clk);
    cmd_valid = 1'b1;
    cmd_write = w;
    cmd_code = c;
    cmd_wdata = d;
    @(negedge clk);
    cmd_valid = 1'b0;
    // Released data lines do not keep the last value
    cmd_wdata = ~d;
    nack = cmd_nack;
    rd = cmd_rdata;
  endtask
endmodule

// ### bench/testbench.sv
`timescale 1ns/1ps
module testbench;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic cmd_valid, cmd_write, cmd_nack, nk;
  logic chan_running, chan_enable, seq_ramping, alert_mask_vin_uv;
  logic fault_busy, fault_cml, conversion_on, vin_ov_fault, status_word_input;
  logic status_input_uv_warn, alert_n, range_low, servo_enable, temp_direct;
  logic pwm_protocol_alt, discontinuous_conduction;
  logic [7:0] cmd_code, refresh_cycles, m;
  logic [15:0] cmd_wdata, cmd_rdata, vin_meas, vout_setpoint, rv;
  int n_fail = 0;
  int total_checks = 0;
  int n;
  localparam logic [23:0] TBL [16] = '{24'h20_0014, 24'h21_1000, 24'h24_5800,
    24'h25_10cd, 24'h26_0f33, 24'h35_cb40, 24'h36_cb00, 24'h40_119a, 24'h42_1133,
    24'h43_0ecd, 24'h44_0e66, 24'h55_d3e0, 24'h58_cb26, 24'ha5_599a, 24'hd3_8000,
    24'hd4_0000};
  localparam logic [15:0] RC [4] = '{16'h0005, 16'h000a, 16'h0019, 16'h0032};
  always #2.5 clk = ~clk;
  pwmcmd_host pwmcmd_host_i (.clk(clk), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
    .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .cmd_nack(cmd_nack), .cmd_rdata(cmd_rdata));
  pwmcmd_regs pwmcmd_regs_i (.clk(clk), .rst_n(rst_n), .cmd_valid(cmd_valid),
    .cmd_write(cmd_write), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata),
    .cmd_nack(cmd_nack), .cmd_rdata(cmd_rdata), .chan_running(chan_running),
    .chan_enable(chan_enable), .seq_ramping(seq_ramping), .vin_meas(vin_meas),
    .alert_mask_vin_uv(alert_mask_vin_uv), .fault_busy(fault_busy),
    .fault_cml(fault_cml), .conversion_on(conversion_on), .vin_ov_fault(vin_ov_fault),
    .status_word_input(status_word_input), .status_input_uv_warn(status_input_uv_warn),
    .alert_n(alert_n), .range_low(range_low), .servo_enable(servo_enable),
    .temp_direct(temp_direct), .refresh_cycles(refresh_cycles),
    .pwm_protocol_alt(pwm_protocol_alt),
    .discontinuous_conduction(discontinuous_conduction), .vout_setpoint(vout_setpoint));
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    total_checks++;
    if (g !== e) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] c, input logic [15:0] d);
    pwmcmd_host_i.xfer(1'b1, c, d, nk, rv);
  endtask
  task automatic rd(input logic [7:0] c, input logic [15:0] e);
    pwmcmd_host_i.xfer(1'b0, c, 16'h0000, nk, rv);
    chk($sformatf("read %h", c), e, rv);
  endtask
  task automatic hold();
    repeat (4) @(negedge clk);
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    chan_running = 1'b0;
    chan_enable = 1'b0;
    seq_ramping = 1'b0;
    alert_mask_vin_uv = 1'b0;
    // Start between the off and on thresholds, so conversion must wait
    vin_meas = 16'hcb10;
    repeat (12) @(negedge clk);
    rst_n = 1'b1;
    for (int i = 0; i < 16; i++) rd(TBL[i][23:16], TBL[i][15:0]);
    chk("busy", 16'h0000, 16'(fault_busy));
    chk("cml", 16'h0000, 16'(fault_cml));
    chk("ov", 16'h0000, 16'(vin_ov_fault));
    chk("conv", 16'h0000, 16'(conversion_on));
    for (int i = 1; i < 15; i++) begin
      if (i == 13) continue;
      wr(TBL[i][23:16], TBL[i][15:0] ^ 16'h0001);
      rd(TBL[i][23:16], TBL[i][15:0] ^ 16'h0001);
      wr(TBL[i][23:16], TBL[i][15:0]);
    end
    wr(8'h20, 16'h0055);
    chk("cml", 16'h0001, 16'(fault_cml));
    chk("nack", 16'h0000, 16'(nk));
    rd(8'h20, 16'h0014);
    wr(8'ha5, 16'h0001);
    rd(8'ha5, 16'h599a);
    rd(8'h99, 16'h0000);
    chk("nack", 16'h0001, 16'(nk));
    for (int k = 0; k < 4; k++) begin
      m = k[0] ? (8'he7 | 8'(k << 3)) : 8'(k << 3);
      wr(8'hd4, {8'h00, m});
      rd(8'hd4, {8'h00, m});
      chk("range", 16'(k[0]), 16'(range_low));
      chk("servo", 16'(k[0]), 16'(servo_enable));
      chk("temp", 16'(k[0]), 16'(temp_direct));
      chk("refresh", RC[k], 16'(refresh_cycles));
      chk("proto", 16'(k[0]), 16'(pwm_protocol_alt));
      chk("discont", 16'(k[0]), 16'(discontinuous_conduction));
    end
    wr(8'hd3, 16'h8001);
    chk("servo", 16'h0000, 16'(servo_enable));
    wr(8'hd3, 16'h8000);
    chk("servo", 16'h0001, 16'(servo_enable));
    chk("busy", 16'h0000, 16'(fault_busy));
    chan_running = 1'b1;
    wr(8'hd4, 16'h0000);
    chk("nack", 16'h0001, 16'(nk));
    chk("busy", 16'h0001, 16'(fault_busy));
    chk("range", 16'h0001, 16'(range_low));
    chan_running = 1'b0;
    rd(8'hd4, 16'h00ff);
    vin_meas = 16'hcb10;
    hold();
    chk("conv", 16'h0000, 16'(conversion_on));
    chk("uv", 16'h0000, 16'(status_input_uv_warn));
    chk("alert", 16'h0001, 16'(alert_n));
    vin_meas = 16'hcb50;
    chan_enable = 1'b1;
    hold();
    chk("conv", 16'h0001, 16'(conversion_on));
    vin_meas = 16'hcb10;
    hold();
    chk("word", 16'h0001, 16'(status_word_input));
    chk("uv", 16'h0001, 16'(status_input_uv_warn));
    chk("alert", 16'h0000, 16'(alert_n));
    alert_mask_vin_uv = 1'b1;
    hold();
    chk("alert", 16'h0001, 16'(alert_n));
    vin_meas = 16'hcb00;
    hold();
    chk("conv", 16'h0000, 16'(conversion_on));
    wr(8'h55, 16'hcb60);
    vin_meas = 16'hcb70;
    hold();
    chk("ov", 16'h0001, 16'(vin_ov_fault));
    seq_ramping = 1'b1;
    wr(8'h21, 16'h1010);
    hold();
    chk("setpoint", 16'h1000, vout_setpoint);
    seq_ramping = 1'b0;
    for (n = 0; n < 40 && vout_setpoint !== 16'h1010; n++) @(negedge clk);
    chk("setpoint", 16'h1010, vout_setpoint);
    chk("slew", 16'h0001, 16'(n > 8));
    // Reset in mid-run clears sticky flags and reloads defaults
    @(negedge clk);
    rst_n = 1'b0;
    repeat (3) @(negedge clk);
    rst_n = 1'b1;
    chk("busy", 16'h0000, 16'(fault_busy));
    chk("cml", 16'h0000, 16'(fault_cml));
    chk("ov", 16'h0000, 16'(vin_ov_fault));
    chk("uv", 16'h0000, 16'(status_input_uv_warn));
    chk("range", 16'h0000, 16'(range_low));
    chk("setpoint", 16'h1000, vout_setpoint);
    rd(8'h55, 16'hd3e0);
    rd(8'h21, 16'h1000);
    close_out();
  end
endmodule
